/* File: rt_mode_code_handler.sv */
/*
  Mode-code handler of a dual-redundant remote terminal: decodes mode
  codes 00100..10011 framed by the word decoder, sets status and
  self-test bits, asks the encoder for replies and runs post-status actions.
  Assumes the framer and encoder run on core_clk and pulse their strobes
  for one cycle; illegal_n and rt_flag_req_n are asynchronous pins.
*/
// Local design decisions: the address-and-strobe port and the placing of the registers.
// Functional notes
// - override shutdown replies status, then re-enables redundant transmitter.
// - valid broadcast sets broadcast-received and sends no status.
// - inhibit flag replies status, then blocks all terminal flag setting.
// - inhibit lifted only by override-inhibit or reset-terminal codes.
// - override-inhibit replies status and restores terminal flag setting.
// - reset-terminal replies status, then clears shutdown, self-test word, inhibit.
// - reserved codes reply with clear status and no data.
// - reserved code marked illegal sets message error, status only.
// - invalid command word is ignored, no response at all.
// - no-data code with data word: no status, message error, high count.
// - transmit self-test with data word: no status, message error only.
// - codes 00101..01000 with direction zero: message error, direction error.
// - reserved code with direction zero: message error, illegal mode code.
// - broadcast direction zero adds broadcast-received, except transmit last command and transmit self-test; codes per group.
// - transmit vector sends status then one vector word.
// - transmit-type codes broadcast: no status, error, received, illegal.
// - transmit-type codes direction zero: error, direction, low count; broadcast transmit last command gets no low count.
// - synchronize-with-data writes the data word to memory before status.
// - synchronize without data word: no status, error, low count.
// - synchronize with extra data words: no status, error, high count.
// - synchronize direction one: no status, error, direction, high count.
// - transmit last command keeps registers, sends status and last command.
// - transmit self-test sends word unchanged; send errors show next status.
// - shutdown code stops redundant channel transmission after status.
`timescale 1ns/100ps

module rt_mode_code_handler
  import mode_code_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               cmd_stb,
  input  wire cmd_word_t          cmd_word,
  input  wire logic               cmd_ok,
  input  wire logic               data_stb,
  input  wire logic [15:0]        data_word,
  input  wire logic               msg_end,
  input  wire logic               tx_done,
  input  wire logic               tx_err,
  input  wire logic               illegal_n,
  input  wire logic               rt_flag_req_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [15:0]             reg_rdata,
  output reply_t                  reply,
  output status_bits_t            rt_status_reply,
  output logic [BIT_WIDTH-1:0]    bit_word,
  output logic                    mem_wr,
  output logic [15:0]             mem_data,
  output logic                    redundant_tx_off,
  output logic                    tflag_inhibit
);

  typedef enum logic [1:0] {S_IDLE, S_COLLECT, S_REPLY, S_WAIT_TX} state_t;

  typedef struct packed {
    logic me;
    logic brcv;
    logic dir;
    logic ill;
    logic hwc;
    logic lwc;
    logic reply;
    logic act;
  } verdict_t;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mode(input cmd_word_t c);
    is_mode = (c.subaddr == SA_MODE_ZERO) || (c.subaddr == SA_MODE_ONES);
  endfunction

  function automatic logic in_scope(input logic [4:0] code);
    in_scope = (code >= MC_TX_SHUT) && (code <= MC_TX_BIT);
  endfunction

  // judgement of one finished mode message; direction faults outrank count faults
  function automatic verdict_t judge(input logic [4:0] code, input logic d, input logic bc,
                                     input logic [1:0] n, input logic ill_in);
    verdict_t v;
    logic     rsv;
    logic     xmt;
    v   = '0;
    rsv = (code >= MC_RSV_LO) && (code <= MC_RSV_HI);
    xmt = (code == MC_TX_VECTOR) || (code == MC_TX_LAST) || (code == MC_TX_BIT);
    if (code == MC_SYNC_DATA) begin
      if (d) begin
        v.me = 1'b1; v.dir = 1'b1; v.hwc = 1'b1;
      end else if (n == 2'd0) begin
        v.me = 1'b1; v.lwc = 1'b1;
      end else if (n != 2'd1) begin
        v.me = 1'b1; v.hwc = 1'b1;
      end else begin
        v.act = 1'b1; v.reply = !bc;
      end
      v.brcv = bc;
    end else if (xmt) begin
      if (!d) begin
        v.me  = 1'b1; v.dir = 1'b1;
        v.lwc = !(bc && code == MC_TX_LAST);
        v.ill = bc;
        v.brcv = bc && (code == MC_TX_VECTOR);
      end else if (n != 2'd0) begin
        v.me = 1'b1; v.hwc = (code == MC_TX_VECTOR);
      end else if (bc) begin
        v.me = 1'b1; v.brcv = 1'b1; v.ill = 1'b1;
      end else begin
        v.reply = 1'b1; v.act = 1'b1;
      end
    end else begin
      if (!d) begin
        v.me   = 1'b1; v.brcv = bc;
        v.dir  = !rsv;
        v.ill  = rsv || (bc && (code == MC_OVR_SHUT || code == MC_TX_SHUT));
      end else if (n != 2'd0) begin
        v.me = 1'b1; v.hwc = 1'b1;
      end else begin
        v.brcv = bc; v.reply = !bc; v.act = !rsv;
      end
    end
    // illegalised command: status only, nothing carried out
    if (ill_in && (v.reply || v.act) && !v.me) begin
      v.me = 1'b1; v.act = 1'b0;
    end
    judge = v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ill_sync_r;
  logic [1:0] flag_sync_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ill_sync_r  <= 2'b11;
      flag_sync_r <= 2'b11;
    end else begin
      ill_sync_r  <= {ill_sync_r[0], illegal_n};
      flag_sync_r <= {flag_sync_r[0], rt_flag_req_n};
    end
  end

  // ----------------------------------------------------------------
  // message sequencing
  // ----------------------------------------------------------------
  state_t        state_r;
  cmd_word_t     pend_r;
  logic          pend_bc_r;
  logic [1:0]    dcount_r;
  logic [15:0]   sync_word_r;
  logic          reply_data_r;
  logic          act_r;
  logic [15:0]   last_cmd_r;
  logic [15:0]   vector_r;
  logic          bro_en_r;
  verdict_t      verdict;
  logic          eval;
  logic          own_cmd;
  logic          bc_now;
  logic          do_action;

  assign bc_now  = bro_en_r && (cmd_word.rt_addr == ADDR_BCAST);
  assign own_cmd = cmd_stb && cmd_ok && is_mode(cmd_word) && in_scope(cmd_word.code);
  assign eval    = (state_r == S_COLLECT) && msg_end;
  assign verdict = judge(pend_r.code, pend_r.dir_tx, pend_bc_r, dcount_r, !ill_sync_r[1]);
  // action lands after the status word, or at once for broadcasts
  assign do_action = ((state_r == S_WAIT_TX) && tx_done && act_r) ||
                     (eval && verdict.act && !verdict.reply);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (own_cmd) begin
            state_r <= S_COLLECT;
          end
        end
        S_COLLECT: begin
          if (msg_end) begin
            state_r <= verdict.reply ? S_REPLY : S_IDLE;
          end
        end
        S_REPLY: begin
          state_r <= S_WAIT_TX;
        end
        S_WAIT_TX: begin
          if (tx_done) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pend_r      <= '0;
      pend_bc_r   <= 1'b0;
      dcount_r    <= 2'd0;
      sync_word_r <= 16'h0000;
    end else if (state_r == S_IDLE && own_cmd) begin
      pend_r    <= cmd_word;
      pend_bc_r <= bc_now;
      dcount_r  <= 2'd0;
    end else if (state_r == S_COLLECT && data_stb) begin
      // count saturates at two: anything above one is too many
      if (dcount_r != 2'd2) begin
        dcount_r <= dcount_r + 2'd1;
      end
      if (dcount_r == 2'd0) begin
        sync_word_r <= data_word;
      end
    end
  end

  // last valid command, never a transmit-last-command itself
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      last_cmd_r <= 16'h0000;
    end else if (cmd_stb && cmd_ok &&
                 !(is_mode(cmd_word) && cmd_word.code == MC_TX_LAST) &&
                 !(state_r == S_COLLECT || state_r == S_REPLY)) begin
      last_cmd_r <= cmd_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reply_data_r <= 1'b0;
      act_r        <= 1'b0;
    end else if (eval) begin
      reply_data_r <= !verdict.me && (pend_r.code == MC_TX_VECTOR ||
                      pend_r.code == MC_TX_LAST || pend_r.code == MC_TX_BIT);
      act_r        <= verdict.act;
    end
  end

  // ----------------------------------------------------------------
  // reply request and memory write
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reply <= '0;
    end else if (state_r == S_REPLY) begin
      reply.req       <= 1'b1;
      reply.with_data <= reply_data_r;
      case (pend_r.code)
        MC_TX_VECTOR: reply.word <= vector_r;
        MC_TX_LAST:   reply.word <= last_cmd_r;
        MC_TX_BIT:    reply.word <= {{(16-BIT_WIDTH){1'b0}}, bit_word};
        default:      reply.word <= 16'h0000;
      endcase
    end else begin
      reply.req <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mem_wr   <= 1'b0;
      mem_data <= 16'h0000;
    end else begin
      mem_wr <= eval && verdict.act && (pend_r.code == MC_SYNC_DATA);
      if (eval) begin
        mem_data <= sync_word_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // status reply and self-test word
  // ----------------------------------------------------------------
  logic keep_status;
  assign keep_status = (pend_r.code == MC_TX_LAST) && !verdict.me;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rt_status_reply.me   <= 1'b0;
      rt_status_reply.brcv <= 1'b0;
    end else if (eval && !keep_status) begin
      rt_status_reply.me   <= verdict.me;
      rt_status_reply.brcv <= verdict.brcv;
    end else if (state_r == S_WAIT_TX && tx_err) begin
      rt_status_reply.me   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rt_status_reply.tflag <= 1'b0;
    end else begin
      rt_status_reply.tflag <= !flag_sync_r[1] && !tflag_inhibit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bit_word <= '0;
    end else if (do_action && pend_r.code == MC_RESET_RT) begin
      bit_word <= '0;
    end else begin
      // errors accumulate until a terminal reset
      if (eval) begin
        bit_word[BIT_DIR_ERR]  <= bit_word[BIT_DIR_ERR]  | verdict.dir;
        bit_word[BIT_ILL_MODE] <= bit_word[BIT_ILL_MODE] | verdict.ill;
        bit_word[BIT_HIGH_WC]  <= bit_word[BIT_HIGH_WC]  | verdict.hwc;
        bit_word[BIT_LOW_WC]   <= bit_word[BIT_LOW_WC]   | verdict.lwc;
      end
      bit_word[BIT_TX_SHUT] <= redundant_tx_off;
    end
  end

  // ----------------------------------------------------------------
  // post-status actions
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      redundant_tx_off <= 1'b0;
      tflag_inhibit    <= 1'b0;
    end else if (do_action) begin
      case (pend_r.code)
        MC_TX_SHUT:  redundant_tx_off <= 1'b1;
        MC_OVR_SHUT: redundant_tx_off <= 1'b0;
        MC_INH_FLAG: tflag_inhibit    <= 1'b1;
        MC_OVR_INH:  tflag_inhibit    <= 1'b0;
        MC_RESET_RT: begin
          redundant_tx_off <= 1'b0;
          tflag_inhibit    <= 1'b0;
        end
        default: begin
          redundant_tx_off <= redundant_tx_off;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vector_r <= VECTOR_RST;
      bro_en_r <= BRO_EN_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_VECTOR) begin
        vector_r <= reg_wdata;
      end
      if (reg_addr == REG_CONTROL) begin
        bro_en_r <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          reg_rdata <= 16'h0000;
          reg_rdata[STATUS_ME_POS]    <= rt_status_reply.me;
          reg_rdata[STATUS_BRCV_POS]  <= rt_status_reply.brcv;
          reg_rdata[STATUS_TFLAG_POS] <= rt_status_reply.tflag;
        end
        REG_BITWORD: reg_rdata <= {{(16-BIT_WIDTH){1'b0}}, bit_word};
        REG_VECTOR:  reg_rdata <= vector_r;
        REG_LASTCMD: reg_rdata <= last_cmd_r;
        REG_CONTROL: reg_rdata <= {15'h0000, bro_en_r};
        default:     reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_invalid_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == S_IDLE && cmd_stb && !cmd_ok) |=> (state_r == S_IDLE) [*2])
    else $error("invalid command was not ignored");

  a_bcast_silent: assert property (@(posedge core_clk) disable iff (!resetn)
    (eval && pend_bc_r) |=> !reply.req ##1 !reply.req)
    else $error("broadcast mode command produced a reply");

  a_sync_mem_first: assert property (@(posedge core_clk) disable iff (!resetn)
    (reply.req && pend_r.code == MC_SYNC_DATA && !rt_status_reply.me) |-> $past(mem_wr))
    else $error("sync status sent without prior memory write");

  a_inhibit_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(tflag_inhibit) |-> !rt_status_reply.tflag)
    else $error("terminal flag set while inhibited");

  a_override_shut: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == S_WAIT_TX && tx_done && act_r && pend_r.code == MC_OVR_SHUT)
      |=> !redundant_tx_off)
    else $error("override shutdown did not re-enable transmitter");

  a_shut_after_status: assert property (@(posedge core_clk) disable iff (!resetn)
    (reply.req && pend_r.code == MC_TX_SHUT && !redundant_tx_off)
      |-> !redundant_tx_off until (state_r == S_IDLE))
    else $error("shutdown took effect before status finished");

  a_vector_word: assert property (@(posedge core_clk) disable iff (!resetn)
    (reply.req && pend_r.code == MC_TX_VECTOR && !rt_status_reply.me)
      |-> reply.with_data && reply.word == vector_r)
    else $error("vector reply lacks the vector word");

  a_last_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
    (eval && keep_status) |=> $stable(rt_status_reply.me) && $stable(bit_word))
    else $error("transmit last command altered registers");

  a_reserved_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (reply.req && pend_r.code >= MC_RSV_LO && pend_r.code <= MC_RSV_HI)
      |-> !reply.with_data)
    else $error("reserved code reply carried data");

  a_illegal_nodata: assert property (@(posedge core_clk) disable iff (!resetn)
    (eval && verdict.reply && !ill_sync_r[1]) |=> ##1 (reply.req && !reply.with_data))
    else $error("illegal command still sent data");

endmodule

/* File: mode_code_pkg.sv */
/*
  Package for the mode-code handler: command word layout, mode codes,
  status reply and self-test word fields, register offsets and reset values.
  Assumes a single 100 MHz core clock and a message framer on the same clock.
*/
package mode_code_pkg;

  // ----------------------------------------------------------------
  // command word and replies
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] rt_addr;
    logic       dir_tx;
    logic [4:0] subaddr;
    logic [4:0] code;
  } cmd_word_t;

  typedef struct packed {
    logic me;
    logic brcv;
    logic tflag;
  } status_bits_t;

  typedef struct packed {
    logic        req;
    logic        with_data;
    logic [15:0] word;
  } reply_t;

  localparam logic [4:0] SA_MODE_ZERO  = 5'h00;
  localparam logic [4:0] SA_MODE_ONES  = 5'h1f;
  localparam logic [4:0] ADDR_BCAST    = 5'h1f;

  localparam logic [4:0] MC_TX_SHUT    = 5'h04;
  localparam logic [4:0] MC_OVR_SHUT   = 5'h05;
  localparam logic [4:0] MC_INH_FLAG   = 5'h06;
  localparam logic [4:0] MC_OVR_INH    = 5'h07;
  localparam logic [4:0] MC_RESET_RT   = 5'h08;
  localparam logic [4:0] MC_RSV_LO     = 5'h09;
  localparam logic [4:0] MC_RSV_HI     = 5'h0f;
  localparam logic [4:0] MC_TX_VECTOR  = 5'h10;
  localparam logic [4:0] MC_SYNC_DATA  = 5'h11;
  localparam logic [4:0] MC_TX_LAST    = 5'h12;
  localparam logic [4:0] MC_TX_BIT     = 5'h13;

  // ----------------------------------------------------------------
  // self-test word bit positions (14 bits)
  // ----------------------------------------------------------------
  localparam int BIT_DIR_ERR   = 0;
  localparam int BIT_ILL_MODE  = 1;
  localparam int BIT_HIGH_WC   = 2;
  localparam int BIT_LOW_WC    = 3;
  localparam int BIT_TX_SHUT   = 4;
  localparam int BIT_WIDTH     = 14;

  localparam int STATUS_ME_POS    = 10;
  localparam int STATUS_BRCV_POS  = 4;
  localparam int STATUS_TFLAG_POS = 0;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_STATUS  = 8'h00;
  localparam logic [7:0]  REG_BITWORD = 8'h04;
  localparam logic [7:0]  REG_VECTOR  = 8'h08;
  localparam logic [7:0]  REG_LASTCMD = 8'h0c;
  localparam logic [7:0]  REG_CONTROL = 8'h10;
  localparam logic [15:0] VECTOR_RST  = 16'h0000;
  localparam logic        BRO_EN_RST  = 1'b1;

endpackage

/* File: bc_model.sv */
/*
  Bus controller and reply encoder model for the mode-code handler.
  Assumes one core_clk for both sides and a one-cycle reply.req pulse.
*/
`timescale 1ns/100ps

module bc_model
  import mode_code_pkg::*;
(
  input  wire logic        core_clk,
  input  wire reply_t      reply,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_data,
  output cmd_word_t        cmd_word,
  output logic             cmd_stb,
  output logic             cmd_ok,
  output logic             data_stb,
  output logic [15:0]      data_word,
  output logic             msg_end,
  output logic             tx_done,
  output logic             tx_err
);
  logic        rep_seen, rep_wd, mem_seen, mem_early, err_next;
  logic [15:0] rep_word, mem_val;
  wire  [17:0] rep_sum = {rep_seen, rep_wd, rep_wd ? rep_word : 16'h0};
  wire  [17:0] mem_sum = {mem_seen, mem_early, mem_val};

  initial begin
    {cmd_stb, cmd_ok, data_stb, msg_end, tx_done, tx_err, err_next} = '0;
    cmd_word = '0;
    data_word = '0;
  end

  // ----------------------------------------------------------------
  // encoder: finishes each reply after a varying delay
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    tx_done <= 1'b0;
    if (reply.req === 1'b1) begin
      rep_seen <= 1'b1;
      rep_wd   <= reply.with_data;
      rep_word <= reply.word;
      tx_err   <= err_next;
      @(posedge core_clk);
      tx_err <= 1'b0;
      repeat ($urandom % 20) @(posedge core_clk);
      tx_done <= 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (mem_wr === 1'b1) begin
      mem_seen  <= 1'b1;
      mem_early <= !rep_seen;
      mem_val   <= mem_data;
    end
  end

  // ----------------------------------------------------------------
  // one message: command, nd data words, then the gap
  // ----------------------------------------------------------------
  task automatic send(input cmd_word_t cw, input logic ok, input int nd, input logic [15:0] d);
    {rep_seen, rep_wd, mem_seen, mem_early} = '0;
    rep_word = '0;
    @(posedge core_clk);
    cmd_stb  <= 1'b1;
    cmd_word <= cw;
    cmd_ok   <= ok;
    @(posedge core_clk);
    cmd_stb  <= 1'b0;
    cmd_ok   <= ~ok;
    // idle lines move so a stale value is never taken
    cmd_word <= ~cw;
    for (int i = 0; i < nd; i++) begin
      data_stb  <= 1'b1;
      data_word <= d + 16'(i);
      @(posedge core_clk);
    end
    data_stb  <= 1'b0;
    data_word <= ~d;
    msg_end   <= 1'b1;
    @(posedge core_clk);
    msg_end <= 1'b0;
    // room for the slowest encoder answer
    repeat (32) @(posedge core_clk);
  endtask
endmodule

/* File: rt_mode_code_handler_test.sv */
/*
  Self-checking bench for the mode-code handler.
  Assumes bc_model plays the bus controller and the reply encoder.
*/
`timescale 1ns/100ps

module rt_mode_code_handler_test
  import mode_code_pkg::*;
;
  logic core_clk, resetn, cmd_stb, cmd_ok, data_stb, msg_end, tx_done, tx_err;
  logic illegal_n, rt_flag_req_n, reg_wr, reg_rd, mem_wr, redundant_tx_off, tflag_inhibit;
  logic [15:0] data_word, reg_wdata, reg_rdata, mem_data, v, vv;
  logic [7:0]  reg_addr;
  logic [13:0] t;
  cmd_word_t   cmd_word, w;
  reply_t      reply;
  status_bits_t rt_status_reply;
  logic [BIT_WIDTH-1:0] bit_word;
  int num_errors, checks_done;
  // code, dir/bcast/count nibble, broadcast-received, lwc/hwc/ill/dir flags
  logic [13:0] tbl [11] = '{{5'h06, 4'h0, 1'b0, 4'h1}, {5'h0a, 4'h0, 1'b0, 4'h2},
    {5'h05, 4'h4, 1'b1, 4'h3}, {5'h0c, 4'h4, 1'b1, 4'h2}, {5'h07, 4'h9, 1'b0, 4'h4},
    {5'h13, 4'h9, 1'b0, 4'h0}, {5'h10, 4'hc, 1'b1, 4'h2}, {5'h12, 4'h0, 1'b0, 4'h9},
    {5'h11, 4'h0, 1'b0, 4'h8}, {5'h11, 4'h2, 1'b0, 4'h4}, {5'h11, 4'h9, 1'b0, 4'h5}};

  rt_mode_code_handler rt_mode_code_handler_inst (.core_clk, .resetn, .cmd_stb, .cmd_word,
    .cmd_ok, .data_stb, .data_word, .msg_end, .tx_done, .tx_err, .illegal_n, .rt_flag_req_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reply, .rt_status_reply, .bit_word,
    .mem_wr, .mem_data, .redundant_tx_off, .tflag_inhibit);
  bc_model bc_model_inst (.core_clk, .reply, .mem_wr, .mem_data, .cmd_word, .cmd_stb,
    .cmd_ok, .data_stb, .data_word, .msg_end, .tx_done, .tx_err);

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] ra();
    ra = 5'($urandom % 31);
  endfunction

  function automatic cmd_word_t cw(input logic [4:0] a, input logic d, input logic [4:0] mc);
    cw = '{a, d, ($urandom % 2) ? SA_MODE_ONES : SA_MODE_ZERO, mc};
  endfunction

  function automatic logic [BIT_WIDTH-1:0] bw(input logic [4:0] f);
    bw = '0;
    bw[BIT_DIR_ERR]  = f[0];
    bw[BIT_ILL_MODE] = f[1];
    bw[BIT_HIGH_WC]  = f[2];
    bw[BIT_LOW_WC]   = f[3];
    bw[BIT_TX_SHUT]  = f[4];
  endfunction

  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    q = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic msg(input cmd_word_t m, input int nd = 0, input logic ok = 1'b1);
    bc_model_inst.send(m, ok, nd, vv);
  endtask

  task automatic res(input logic [1:0] rk, input logic [15:0] d, input logic [1:0] mb,
                     input logic [4:0] f);
    chk(bc_model_inst.rep_sum, {rk, d});
    chk({rt_status_reply.me, rt_status_reply.brcv, 2'b00, bit_word}, {mb, 2'b00, bw(f)});
  endtask

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    illegal_n = 1'b1;
    rt_flag_req_n = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(51));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rd(REG_CONTROL, v);
    chk(18'(v), 18'h1);
    rd(REG_VECTOR, v);
    chk(18'(v), 18'h0);
    vv = 16'($urandom);
    wr(REG_VECTOR, vv);
    rd(8'h14, v);
    chk(18'(v), 18'h0);
    msg(cw(ra(), 1'b1, MC_TX_VECTOR));
    res(2'b11, vv, 2'b00, 5'h0);
    // broadcast recognition off: address 31 is then an ordinary terminal
    wr(REG_CONTROL, 16'h0000);
    msg(cw(ADDR_BCAST, 1'b1, MC_TX_VECTOR));
    res(2'b11, vv, 2'b00, 5'h0);
    wr(REG_CONTROL, 16'h0001);
    msg(cw(ra(), 1'b1, MC_TX_SHUT));
    res(2'b10, 16'h0, 2'b00, 5'h10);
    msg(cw(ra(), 1'b1, MC_OVR_SHUT));
    chk(18'(redundant_tx_off), 18'h0);
    msg(cw(ADDR_BCAST, 1'b1, MC_OVR_SHUT));
    res(2'b00, 16'h0, 2'b01, 5'h0);
    msg(cw(ra(), 1'b1, MC_RESET_RT), 0, 1'b0);
    res(2'b00, 16'h0, 2'b01, 5'h0);
    msg(cw(ra(), 1'b1, MC_INH_FLAG));
    rt_flag_req_n <= 1'b0;
    msg(cw(ra(), 1'b1, MC_TX_SHUT));
    chk(18'({tflag_inhibit, rt_status_reply.tflag}), 18'h2);
    msg(cw(ra(), 1'b1, MC_OVR_INH));
    chk(18'({tflag_inhibit, rt_status_reply.tflag}), 18'h1);
    msg(cw(ra(), 1'b1, MC_INH_FLAG));
    msg(cw(ra(), 1'b1, MC_RESET_RT));
    chk(18'({tflag_inhibit, rt_status_reply.tflag, redundant_tx_off}), 18'h2);
    res(2'b10, 16'h0, 2'b00, 5'h0);
    rt_flag_req_n <= 1'b1;
    for (int m = MC_RSV_LO; m <= MC_RSV_HI; m++) begin
      msg(cw(ra(), 1'b1, 5'(m)));
      res(2'b10, 16'h0, 2'b00, 5'h0);
    end
    illegal_n <= 1'b0;
    msg(cw(ra(), 1'b1, MC_RSV_HI));
    res(2'b10, 16'h0, 2'b10, 5'h0);
    illegal_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    msg(cw(ra(), 1'b0, MC_SYNC_DATA), 1);
    chk(bc_model_inst.mem_sum, {2'b11, vv});
    res(2'b10, 16'h0, 2'b00, 5'h0);
    foreach (tbl[i]) begin
      t = tbl[i];
      msg(cw(ra(), 1'b1, MC_RESET_RT));
      msg(cw(t[7] ? ADDR_BCAST : ra(), t[8], t[13:9]), int'(t[6:5]));
      if (i < 6) begin
        res(2'b00, 16'h0, {1'b1, t[4]}, {1'b0, t[3:0]});
      end else begin
        res(2'b00, 16'h0, {1'b1, t[4]}, {1'b0, t[3:0]});
      end
    end
    w = cw(ra(), 1'b1, MC_RSV_LO);
    msg(w);
    msg(cw(ra(), 1'b1, MC_TX_LAST));
    res(2'b11, w, 2'b00, 5'h5);
    bc_model_inst.err_next = 1'b1;
    msg(cw(ra(), 1'b1, MC_TX_BIT));
    res(2'b11, 16'(bw(5'h5)), 2'b10, 5'h5);
    conclude();
  end
endmodule
